// ===== hdl/pcb_defs.svh
// Constants for the configuration forwarding block of a two-bus bridge.
// Assumes inclusion by bare name from files that use the macros.
`ifndef PCB_DEFS_SVH
`define PCB_DEFS_SVH

// ==========================================================
// Bus commands.
`define PCB_CMD_CFG_RD  4'hA
`define PCB_CMD_CFG_WR  4'hB
`define PCB_CMD_SPECIAL 4'h1

// ==========================================================
// Configuration address fields.
`define PCB_TYPE_F   1:0
`define PCB_TYPE0    2'h0
`define PCB_TYPE1    2'h1
`define PCB_BUS_F    23:16
`define PCB_DEV_F    15:11
`define PCB_DEV_LO_F 14:11
`define PCB_DEV_HI   15
`define PCB_FUNC_F   10:8
`define PCB_REG_F    7:2
`define PCB_IDSEL_F  31:16
`define PCB_DEV_ALL  5'h1F
`define PCB_FUNC_ALL 3'h7
`define PCB_REG_ZERO 6'h00
`define PCB_DEV_ZERO 5'h00
`define PCB_IDSEL_ONE  16'h0001
`define PCB_IDSEL_NONE 16'h0000

// ==========================================================
// Data values.
`define PCB_ALL_ONES 32'hFFFFFFFF
`define PCB_ZERO32   32'h00000000

`endif

// ===== hdl/pcb_pkg.sv
// Types shared by the configuration forwarding block and its decoder.
// Assumes nothing of its surroundings.
package pcb_pkg;

  typedef enum logic [2:0] {
    FWD_NONE  = 3'h0,
    FWD_T0    = 3'h1,
    FWD_T1_DN = 3'h2,
    FWD_T1_UP = 3'h3,
    FWD_SPC   = 3'h4
  } pcb_fwd_t;

  typedef enum logic [2:0] {
    RSP_NONE   = 3'h0,
    RSP_RETRY  = 3'h1,
    RSP_TRDY   = 3'h2,
    RSP_DISC   = 3'h3,
    RSP_TABORT = 3'h4
  } pcb_resp_t;

  typedef enum logic [1:0] {
    TERM_NORMAL = 2'h0,
    TERM_RETRY  = 2'h1,
    TERM_MABORT = 2'h2,
    TERM_TABORT = 2'h3
  } pcb_term_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ISSUE = 2'h1,
    ST_WAIT  = 2'h3,
    ST_DONE  = 2'h2
  } pcb_state_t;

endpackage : pcb_pkg

// ===== hdl/pcb_dec_if.sv
// Carrier between the forwarding engine and its address decoder.
// Assumes the package is compiled first.
`timescale 1ns/1ps
interface pcb_dec_if;
  import pcb_pkg::*;
  logic            from_sec;
  logic [31:0]     addr;
  logic [3:0]      cmd;
  logic [7:0]      pri_bus;
  logic [7:0]      sec_bus;
  logic [7:0]      sub_bus;
  pcb_fwd_t        fwd;
  logic [31:0]     out_addr;
  logic [3:0]      out_cmd;
  logic            no_idsel;

  modport eng (output from_sec, addr, cmd, pri_bus, sec_bus, sub_bus,
               input fwd, out_addr, out_cmd, no_idsel);
  modport dec (input from_sec, addr, cmd, pri_bus, sec_bus, sub_bus,
               output fwd, out_addr, out_cmd, no_idsel);
endinterface : pcb_dec_if

// ===== hdl/pcb_decode.sv
// Address-phase decoder: classifies a configuration attempt and builds
// the address and command to issue on the target bus.
// Assumes purely combinational use by the forwarding engine.
`timescale 1ns/1ps
`include "pcb_defs.svh"
module pcb_decode (
  pcb_dec_if.dec d
);
  import pcb_pkg::*;

  logic       is_t1;
  logic       is_rd;
  logic       is_wr;
  logic [7:0] bus;
  logic       in_dn;
  logic       in_all;
  logic       spc_key;

  // ==========================================================
  // Classification and address rewrite.
  always_comb begin
    is_t1   = d.addr[`PCB_TYPE_F] == `PCB_TYPE1;
    is_rd   = d.cmd == `PCB_CMD_CFG_RD;
    is_wr   = d.cmd == `PCB_CMD_CFG_WR;
    bus     = d.addr[`PCB_BUS_F];
    in_dn   = (bus > d.sec_bus) && (bus <= d.sub_bus);
    in_all  = (bus >= d.sec_bus) && (bus <= d.sub_bus);
    spc_key = is_t1 && is_wr
              && d.addr[`PCB_DEV_F] == `PCB_DEV_ALL
              && d.addr[`PCB_FUNC_F] == `PCB_FUNC_ALL
              && d.addr[`PCB_REG_F] == `PCB_REG_ZERO;
    d.fwd      = FWD_NONE;
    d.out_addr = d.addr;
    d.out_cmd  = d.cmd;
    d.no_idsel = 1'b0;
    // Special-cycle commands are not configuration commands and fall out.
    if (!d.from_sec) begin
      if (is_t1 && (is_rd || is_wr) && bus == d.sec_bus) begin
        if (spc_key) begin
          d.fwd     = FWD_SPC;
          d.out_cmd = `PCB_CMD_SPECIAL;
        end else begin
          d.fwd = FWD_T0;
          d.out_addr[`PCB_TYPE_F] = `PCB_TYPE0;
          d.out_addr[`PCB_DEV_F]  = `PCB_DEV_ZERO;
          if (d.addr[`PCB_DEV_HI]) begin
            d.out_addr[`PCB_IDSEL_F] = `PCB_IDSEL_NONE;
            d.no_idsel = 1'b1;
          end else begin
            d.out_addr[`PCB_IDSEL_F] = `PCB_IDSEL_ONE << d.addr[`PCB_DEV_LO_F];
          end
        end
      end else if (is_t1 && (is_rd || is_wr) && in_dn) begin
        d.fwd = FWD_T1_DN;
      end
    end else begin
      if (spc_key && bus == d.pri_bus) begin
        d.fwd     = FWD_SPC;
        d.out_cmd = `PCB_CMD_SPECIAL;
      end else if (is_t1 && is_wr && !in_all
                   && d.addr[`PCB_DEV_F] == `PCB_DEV_ALL
                   && d.addr[`PCB_FUNC_F] == `PCB_FUNC_ALL) begin
        d.fwd = FWD_T1_UP;
      end
    end
  end

endmodule : pcb_decode

// ===== hdl/pcb_forward.sv
// Configuration forwarding engine of a two-bus bridge: claims Type 1
// attempts, runs one delayed transaction on the target bus, retries
// repeats until it completes, then answers the next matching repeat.
// Assumes all inputs come from logic on clk; the target-bus engine runs
// the bus protocol, including master abort on an unanswered address.
`timescale 1ns/1ps
`include "pcb_defs.svh"

// Notes on behaviour
// - Type 0 generated only downstream, never primary.
// - Claim when type bits 01 and bus equals secondary.
// - Translated address: type bits 00, device field zero.
// - Devices 0 to 15 drive one-hot select line.
// - Devices 16 up: no select line, still forwarded.
// - No select line reached: target bus master abort.
// - Type 0 forwarding delayed, single 32-bit phase.
// - Forward downstream unchanged when bus in subordinate range.
// - Forward writes upstream for out-of-range broadcast address.
// - Type 1 writes delayed, single data phase.
// - Special-cycle commands as target are ignored.
// - Broadcast register-zero write launches a special cycle.
// - Special cycle keeps address and data, swaps command.
// - Special cycle abort hidden; repeat gets TRDY.
// - Multiple phases requested: disconnect in first phase.
module pcb_forward (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ini_valid,
  input  wire logic              ini_from_sec,
  input  wire logic [31:0]       ini_addr,
  input  wire logic [3:0]        ini_cmd,
  input  wire logic [31:0]       ini_data,
  input  wire logic              ini_multi,
  input  wire logic [7:0]        pri_bus,
  input  wire logic [7:0]        sec_bus,
  input  wire logic [7:0]        sub_bus,
  output logic                   tgt_valid,
  output logic                   tgt_to_sec,
  output logic [31:0]            tgt_addr,
  output logic [3:0]             tgt_cmd,
  output logic [31:0]            tgt_data,
  output logic                   tgt_no_idsel,
  input  wire logic              tgt_accept,
  input  wire logic              tgt_done,
  input  wire pcb_pkg::pcb_term_t tgt_term,
  input  wire logic [31:0]       tgt_rdata,
  output logic                   rsp_valid,
  output pcb_pkg::pcb_resp_t     rsp_code,
  output logic [31:0]            rsp_data
);
  import pcb_pkg::*;

  // ==========================================================
  // Decoder of the current address phase.
  pcb_dec_if dif ();

  assign dif.from_sec = ini_from_sec;
  assign dif.addr     = ini_addr;
  assign dif.cmd      = ini_cmd;
  assign dif.pri_bus  = pri_bus;
  assign dif.sec_bus  = sec_bus;
  assign dif.sub_bus  = sub_bus;

  pcb_decode u_dec (
    .d (dif.dec)
  );

  // ==========================================================
  // State of the single delayed transaction.
  pcb_state_t  state;
  pcb_state_t  next_state;
  logic [31:0] held_addr;
  logic [31:0] next_held_addr;
  logic [3:0]  held_cmd;
  logic [3:0]  next_held_cmd;
  logic [31:0] held_data;
  logic [31:0] next_held_data;
  logic        held_sec;
  logic        next_held_sec;
  pcb_fwd_t    held_fwd;
  pcb_fwd_t    next_held_fwd;
  logic        res_abort;
  logic        next_res_abort;
  logic [31:0] res_data;
  logic [31:0] next_res_data;

  logic        next_tgt_valid;
  logic        next_tgt_to_sec;
  logic [31:0] next_tgt_addr;
  logic [3:0]  next_tgt_cmd;
  logic [31:0] next_tgt_data;
  logic        next_tgt_no_idsel;

  logic        next_rsp_valid;
  pcb_resp_t   next_rsp_code;
  logic [31:0] next_rsp_data;

  logic        claim;
  logic        same;

  // A repeat matches when address, command, side and write data agree.
  assign claim = ini_valid && dif.fwd != FWD_NONE;
  assign same  = ini_valid
                 && ini_addr == held_addr
                 && ini_cmd == held_cmd
                 && ini_from_sec == held_sec
                 && (ini_cmd == `PCB_CMD_CFG_RD || ini_data == held_data);

  // ==========================================================
  // Transaction phase and the attempt that it serves.
  always_comb begin
    next_state     = state;
    next_held_addr = held_addr;
    next_held_cmd  = held_cmd;
    next_held_data = held_data;
    next_held_sec  = held_sec;
    next_held_fwd  = held_fwd;
    unique case (state)
      ST_IDLE: begin
        if (claim) begin
          // Latch the attempt and start it as a delayed transaction.
          next_held_addr = ini_addr;
          next_held_cmd  = ini_cmd;
          next_held_data = ini_data;
          next_held_sec  = ini_from_sec;
          next_held_fwd  = dif.fwd;
          next_state     = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (tgt_accept) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (tgt_done) begin
          if (tgt_term == TERM_RETRY) begin
            // The target asked for a retry: issue the same cycle again.
            next_state = ST_ISSUE;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // Only the matching repeat releases the result; others keep waiting.
        if (claim && same) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // Result of the target-bus cycle, kept until the repeat fetches it.
  always_comb begin
    next_res_abort = res_abort;
    next_res_data  = res_data;
    if (state == ST_IDLE && claim) begin
      next_res_abort = 1'b0;
      next_res_data  = `PCB_ZERO32;
    end else if (state == ST_WAIT && tgt_done) begin
      unique case (tgt_term)
        TERM_RETRY: begin
          // Nothing to keep: the same cycle goes out again.
        end
        TERM_NORMAL: begin
          next_res_data = tgt_rdata;
        end
        TERM_MABORT: begin
          // Expected for a special cycle and for a missing select line.
          if (held_fwd == FWD_SPC) begin
            next_res_data = `PCB_ZERO32;
          end else begin
            next_res_data = `PCB_ALL_ONES;
          end
        end
        TERM_TABORT: begin
          next_res_abort = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Request to the target-bus engine, held until it is accepted.
  always_comb begin
    next_tgt_valid    = tgt_valid;
    next_tgt_to_sec   = tgt_to_sec;
    next_tgt_addr     = tgt_addr;
    next_tgt_cmd      = tgt_cmd;
    next_tgt_data     = tgt_data;
    next_tgt_no_idsel = tgt_no_idsel;
    if (state == ST_IDLE && claim) begin
      next_tgt_valid    = 1'b1;
      next_tgt_to_sec   = !ini_from_sec;
      next_tgt_addr     = dif.out_addr;
      next_tgt_cmd      = dif.out_cmd;
      next_tgt_data     = ini_data;
      next_tgt_no_idsel = dif.no_idsel;
    end else if (state == ST_ISSUE && tgt_accept) begin
      next_tgt_valid = 1'b0;
    end else if (state == ST_WAIT && tgt_done && tgt_term == TERM_RETRY) begin
      // Raised again at once, so a target retry costs no extra idle cycle.
      next_tgt_valid = 1'b1;
    end
  end

  // ==========================================================
  // Answer to the initiator, one cycle after each claimed attempt.
  always_comb begin
    next_rsp_valid = 1'b0;
    next_rsp_code  = RSP_NONE;
    next_rsp_data  = `PCB_ZERO32;
    if (claim) begin
      next_rsp_valid = 1'b1;
      next_rsp_code  = RSP_RETRY;
      if (state == ST_DONE && same) begin
        // The initiator repeats: hand over the completion once.
        if (res_abort) begin
          next_rsp_code = RSP_TABORT;
        end else if (ini_multi) begin
          next_rsp_code = RSP_DISC;
          next_rsp_data = res_data;
        end else begin
          next_rsp_code = RSP_TRDY;
          next_rsp_data = res_data;
        end
      end
    end
  end

  // ==========================================================
  // Registers of the transaction phase and the held attempt.
  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= ST_IDLE;
      held_addr <= `PCB_ZERO32;
      held_cmd  <= `PCB_CMD_CFG_RD;
      held_data <= `PCB_ZERO32;
      held_sec  <= 1'b0;
      held_fwd  <= FWD_NONE;
    end else begin
      state     <= next_state;
      held_addr <= next_held_addr;
      held_cmd  <= next_held_cmd;
      held_data <= next_held_data;
      held_sec  <= next_held_sec;
      held_fwd  <= next_held_fwd;
    end
  end

  // ==========================================================
  // Registers of the result.
  always_ff @(posedge clk) begin
    if (rst) begin
      res_abort <= 1'b0;
      res_data  <= `PCB_ZERO32;
    end else begin
      res_abort <= next_res_abort;
      res_data  <= next_res_data;
    end
  end

  // ==========================================================
  // Registers of the target request.
  always_ff @(posedge clk) begin
    if (rst) begin
      tgt_valid    <= 1'b0;
      tgt_to_sec   <= 1'b0;
      tgt_addr     <= `PCB_ZERO32;
      tgt_cmd      <= `PCB_CMD_CFG_RD;
      tgt_data     <= `PCB_ZERO32;
      tgt_no_idsel <= 1'b0;
    end else begin
      tgt_valid    <= next_tgt_valid;
      tgt_to_sec   <= next_tgt_to_sec;
      tgt_addr     <= next_tgt_addr;
      tgt_cmd      <= next_tgt_cmd;
      tgt_data     <= next_tgt_data;
      tgt_no_idsel <= next_tgt_no_idsel;
    end
  end

  // ==========================================================
  // Registers of the answer.
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_code  <= RSP_NONE;
      rsp_data  <= `PCB_ZERO32;
    end else begin
      rsp_valid <= next_rsp_valid;
      rsp_code  <= next_rsp_code;
      rsp_data  <= next_rsp_data;
    end
  end

endmodule : pcb_forward

// ===== tb/pcb_fwd_assertions.sv
// Checker on the ports of the configuration forwarding block.
// Assumes it is bound to pcb_forward.
`timescale 1ns/1ps
`include "pcb_defs.svh"
module pcb_fwd_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ini_valid,
  input wire logic        ini_from_sec,
  input wire logic [31:0] ini_addr,
  input wire logic [3:0]  ini_cmd,
  input wire logic [7:0]  sec_bus,
  input wire logic        tgt_valid,
  input wire logic        tgt_to_sec,
  input wire logic [31:0] tgt_addr,
  input wire logic [3:0]  tgt_cmd,
  input wire logic        tgt_no_idsel,
  input wire logic        tgt_accept,
  input wire logic        rsp_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire t0 = tgt_valid && tgt_addr[1:0] == 2'h0;
  sequence s_held;
    tgt_valid && !tgt_accept;
  endsequence
  sequence s_took;
    tgt_valid && tgt_accept;
  endsequence
  AST_T0_SEC: assert property (t0 |-> tgt_to_sec) else $error("type 0 on primary");
  AST_T0_PRI: assert property (ini_valid && !ini_from_sec && ini_addr[1:0] == 2'h0 |=> !rsp_valid)
    else $error("type 0 attempt claimed");
  AST_CLAIM: assert property (ini_valid && !ini_from_sec && ini_addr[23:16] == sec_bus
    && ini_addr[1:0] == 2'h1 && (ini_cmd == `PCB_CMD_CFG_RD || ini_cmd == `PCB_CMD_CFG_WR) |=> rsp_valid)
    else $error("type 1 attempt not claimed");
  AST_T0_DEV: assert property (t0 |-> tgt_addr[15:11] == 5'h00 && $onehot0(tgt_addr[31:16]))
    else $error("bad type 0 address");
  AST_IDSEL: assert property (t0 && !tgt_no_idsel |-> $onehot(tgt_addr[31:16]))
    else $error("select line missing");
  AST_NOSEL: assert property (tgt_valid && tgt_no_idsel |-> t0 && tgt_addr[31:16] == 16'h0000)
    else $error("upper lines not clear");
  AST_HOLD: assert property (s_held |=> tgt_valid && $stable(tgt_addr) && $stable(tgt_cmd))
    else $error("request changed before accept");
  AST_DROP: assert property (s_took |=> !tgt_valid) else $error("request kept after accept");
  AST_SPC: assert property (tgt_valid && tgt_cmd == `PCB_CMD_SPECIAL |-> tgt_addr[15:0] == 16'hFF01)
    else $error("special cycle from wrong address");
  AST_IGN_SPC: assert property (ini_valid && ini_cmd == `PCB_CMD_SPECIAL |=> !rsp_valid)
    else $error("special cycle claimed");
  AST_NO_UP_RD: assert property (ini_valid && ini_from_sec && ini_cmd == `PCB_CMD_CFG_RD |=> !rsp_valid)
    else $error("upstream read claimed");
  AST_CAUSE: assert property (rsp_valid |-> $past(ini_valid)) else $error("answer without attempt");
endmodule : pcb_fwd_chk

bind pcb_forward pcb_fwd_chk u_chk (.clk(clk), .rst(rst), .ini_valid(ini_valid),
  .ini_from_sec(ini_from_sec), .ini_addr(ini_addr), .ini_cmd(ini_cmd), .sec_bus(sec_bus),
  .tgt_valid(tgt_valid), .tgt_to_sec(tgt_to_sec), .tgt_addr(tgt_addr), .tgt_cmd(tgt_cmd),
  .tgt_no_idsel(tgt_no_idsel), .tgt_accept(tgt_accept), .rsp_valid(rsp_valid));

// ===== tb/pcb_tgt_model.sv
// Target-bus engine model: accepts each request after lat cycles, ends it lat+1 cycles after the accept.
// Assumes the bench sets lat, retries, abort_req and rd_val between requests.
`timescale 1ns/1ps
`include "pcb_defs.svh"
module pcb_tgt_model (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         tgt_valid,
  input  wire logic [3:0]   tgt_cmd,
  input  wire logic         tgt_no_idsel,
  input  wire logic [3:0]   lat,
  input  wire logic [3:0]   retries,
  input  wire logic         abort_req,
  input  wire logic [31:0]  rd_val,
  output logic              tgt_accept,
  output logic              tgt_done,
  output pcb_pkg::pcb_term_t tgt_term,
  output logic [31:0]       tgt_rdata
);
  import pcb_pkg::*;
  logic [3:0] k;
  logic       ma;
  initial begin
    {tgt_accept, tgt_done, tgt_rdata, k} = '0;
    tgt_term = TERM_NORMAL;
    forever begin
      @(negedge clk);
      if (tgt_valid && !rst) begin
        // Nobody answers a special cycle or an unselected device.
        ma = tgt_cmd == `PCB_CMD_SPECIAL || tgt_no_idsel;
        repeat (lat) @(posedge clk);
        tgt_accept <= 1'b1;
        @(posedge clk);
        tgt_accept <= 1'b0;
        repeat (lat) @(posedge clk);
        tgt_done <= 1'b1;
        tgt_rdata <= rd_val;
        if (k < retries) begin
          tgt_term <= TERM_RETRY;
          k = k + 4'h1;
        end else begin
          tgt_term <= abort_req ? TERM_TABORT : ma ? TERM_MABORT : TERM_NORMAL;
          k = 4'h0;
        end
        @(posedge clk);
        tgt_done <= 1'b0;
        tgt_rdata <= ~rd_val;
      end else begin
        tgt_rdata <= ~tgt_rdata;
      end
    end
  end
endmodule : pcb_tgt_model

// ===== tb/tb_top.sv
// Self-checking bench for the configuration forwarding block.
// Assumes the target-bus model and the bound checker are compiled.
`timescale 1ns/1ps
`include "pcb_defs.svh"
module tb_top;
  import pcb_pkg::*;
  localparam logic [3:0] RD = `PCB_CMD_CFG_RD;
  localparam logic [3:0] WR = `PCB_CMD_CFG_WR;
  localparam logic [3:0] SPC = `PCB_CMD_SPECIAL;
  logic        clk, rst, ini_valid, ini_from_sec, ini_multi, abort_req;
  logic        tgt_valid, tgt_to_sec, tgt_no_idsel, tgt_accept, tgt_done, rsp_valid;
  logic [31:0] ini_addr, ini_data, rd_val, tgt_addr, tgt_data, tgt_rdata, rsp_data;
  logic [3:0]  ini_cmd, lat, retries, tgt_cmd;
  logic [7:0]  pri_bus, sec_bus, sub_bus;
  pcb_term_t   tgt_term;
  pcb_resp_t   rsp_code;
  int          err_count, check_count;

  pcb_forward DUT (.clk(clk), .rst(rst), .ini_valid(ini_valid), .ini_from_sec(ini_from_sec),
    .ini_addr(ini_addr), .ini_cmd(ini_cmd), .ini_data(ini_data), .ini_multi(ini_multi),
    .pri_bus(pri_bus), .sec_bus(sec_bus), .sub_bus(sub_bus), .tgt_valid(tgt_valid),
    .tgt_to_sec(tgt_to_sec), .tgt_addr(tgt_addr), .tgt_cmd(tgt_cmd), .tgt_data(tgt_data),
    .tgt_no_idsel(tgt_no_idsel), .tgt_accept(tgt_accept), .tgt_done(tgt_done),
    .tgt_term(tgt_term), .tgt_rdata(tgt_rdata), .rsp_valid(rsp_valid), .rsp_code(rsp_code),
    .rsp_data(rsp_data));
  pcb_tgt_model u_tgt (.clk(clk), .rst(rst), .tgt_valid(tgt_valid), .tgt_cmd(tgt_cmd),
    .tgt_no_idsel(tgt_no_idsel), .lat(lat), .retries(retries), .abort_req(abort_req),
    .rd_val(rd_val), .tgt_accept(tgt_accept), .tgt_done(tgt_done), .tgt_term(tgt_term),
    .tgt_rdata(tgt_rdata));

  task automatic report_and_stop;
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  function automatic logic [31:0] cfg(input logic [7:0] b, input logic [4:0] dv,
                                      input logic [2:0] f, input logic [5:0] r);
    return {8'h00, b, dv, f, r, 2'h1};
  endfunction : cfg

  task automatic attempt(input logic fs, input logic [31:0] a, input logic [3:0] c,
                         input logic [31:0] d, input logic m);
    @(negedge clk);
    {ini_valid, ini_from_sec, ini_addr, ini_cmd, ini_data, ini_multi} = {1'b1, fs, a, c, d, m};
    @(negedge clk);
    ini_valid = 1'b0;
  endtask : attempt

  task automatic xact(input logic fs, input logic [31:0] a, input logic [3:0] c, input logic [31:0] d,
                      input logic m, input logic [31:0] ea, input logic [3:0] ec, input logic ni,
                      input logic [2:0] code, input logic [31:0] ed);
    int n;
    attempt(fs, a, c, d, m);
    chk({rsp_valid, rsp_code}, {1'b1, RSP_RETRY}, "first attempt not retried");
    chk({tgt_valid, tgt_to_sec, tgt_no_idsel, tgt_cmd}, {1'b1, !fs, ni, ec}, "request flags");
    chk(tgt_addr, ea, "request address");
    if (c == WR)
      chk(tgt_data, d, "request data");
    attempt(fs, a, c, d, m);
    chk({rsp_valid, rsp_code}, {1'b1, RSP_RETRY}, "repeat not retried");
    n = 0;
    while (!(tgt_done === 1'b1 && tgt_term !== TERM_RETRY) && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(n < 300, 1'b1, "target bus never finished");
    attempt(fs, a, c, d, m);
    chk({rsp_valid, rsp_code}, {1'b1, code}, "completion code");
    chk(rsp_data, ed, "completion data");
  endtask : xact

  task automatic same(input logic fs, input logic [31:0] a, input logic [3:0] c, input logic [31:0] d,
                      input logic m, input logic [2:0] code, input logic [31:0] ed);
    xact(fs, a, c, d, m, a, c, 1'b0, code, ed);
  endtask : same

  task automatic refuse(input logic fs, input logic [31:0] a, input logic [3:0] c);
    attempt(fs, a, c, 32'h0, 1'b0);
    chk({rsp_valid, tgt_valid}, 2'h0, "foreign attempt claimed");
  endtask : refuse

  task automatic t_type0;
    logic [5:0] r;
    logic       ni;
    for (int dv = 0; dv < 32; dv++) begin
      r = dv[5:0] + 6'h01;
      ni = dv > 15;
      lat = dv[2] ? 4'h6 : 4'h1;
      rd_val = {16'hC0DE, 10'h000, r};
      xact(1'b0, cfg(sec_bus, dv[4:0], 3'h2, r), RD, 32'h0, 1'b0,
           {ni ? 16'h0000 : 16'h0001 << dv[3:0], 5'h00, 3'h2, r, 2'h0}, RD, ni,
           RSP_TRDY, ni ? 32'hFFFFFFFF : rd_val);
    end
    rd_val = 32'h0;
    xact(1'b0, cfg(sec_bus, 5'h03, 3'h0, 6'h01), WR, 32'hA5A5_0001, 1'b1,
         {16'h0008, 5'h00, 3'h0, 6'h01, 2'h0}, WR, 1'b0, RSP_DISC, 32'h0);
    refuse(1'b0, cfg(sec_bus, 5'h01, 3'h0, 6'h01) & 32'hFFFFFFFC, RD);
  endtask : t_type0

  task automatic t_type1;
    lat = 4'h2;
    rd_val = 32'h1234_5678;
    same(1'b0, cfg(8'h06, 5'h04, 3'h1, 6'h02), RD, 32'h0, 1'b0, RSP_TRDY, rd_val);
    rd_val = 32'h0;
    same(1'b0, cfg(8'h09, 5'h05, 3'h0, 6'h03), WR, 32'h0000_0055, 1'b1, RSP_DISC, 32'h0);
    same(1'b1, cfg(8'h0A, 5'h1F, 3'h7, 6'h04), WR, 32'h0000_0066, 1'b0, RSP_TRDY, 32'h0);
    refuse(1'b1, cfg(8'h05, 5'h1F, 3'h7, 6'h04), WR);
    refuse(1'b1, cfg(8'h0A, 5'h1F, 3'h6, 6'h04), WR);
    refuse(1'b1, cfg(8'h0A, 5'h1F, 3'h7, 6'h04), RD);
    refuse(1'b0, cfg(8'h0A, 5'h01, 3'h0, 6'h04), RD);
  endtask : t_type1

  task automatic t_special;
    lat = 4'h3;
    xact(1'b0, cfg(8'h05, 5'h1F, 3'h7, 6'h00), WR, 32'h0000_00C3, 1'b1,
         cfg(8'h05, 5'h1F, 3'h7, 6'h00), SPC, 1'b0, RSP_DISC, 32'h0);
    xact(1'b1, cfg(8'h02, 5'h1F, 3'h7, 6'h00), WR, 32'h0000_0102, 1'b0,
         cfg(8'h02, 5'h1F, 3'h7, 6'h00), SPC, 1'b0, RSP_TRDY, 32'h0);
    refuse(1'b0, cfg(8'h05, 5'h1F, 3'h7, 6'h00), SPC);
    refuse(1'b1, cfg(8'h02, 5'h1F, 3'h7, 6'h00), SPC);
  endtask : t_special

  task automatic t_retry;
    retries = 4'h2;
    same(1'b0, cfg(8'h07, 5'h02, 3'h0, 6'h03), WR, 32'h0BAD_F00D, 1'b0, RSP_TRDY, 32'h0);
    retries = 4'h0;
    abort_req = 1'b1;
    same(1'b0, cfg(8'h08, 5'h02, 3'h0, 6'h03), WR, 32'h0000_0077, 1'b0, RSP_TABORT, 32'h0);
    abort_req = 1'b0;
  endtask : t_retry

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #80000;
    err_count++;
    report_and_stop();
  end

  initial begin
    {ini_valid, ini_from_sec, ini_addr, ini_cmd, ini_data, ini_multi} = '0;
    {pri_bus, sec_bus, sub_bus} = {8'h02, 8'h05, 8'h09};
    {lat, retries, abort_req, rd_val} = {4'h1, 4'h0, 1'b0, 32'h0};
    err_count = 0;
    check_count = 0;
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_type0();
    t_type1();
    t_special();
    t_retry();
    report_and_stop();
  end
endmodule : tb_top
